// File: rtl/serial_port_core.sv
// Serial port: baud selection, mode 0 shift register and mode 1 UART.
// Assumes a Wishbone classic master on clk_i and a Timer 1 overflow
// pulse from same-clock logic; the data pin is split into i/o/oe.
`include "serial_port_params.svh"
`timescale 1ns/10ps
`default_nettype none

module serial_port_core (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone classic slave
  input  wire serial_port_pkg::wb_req_type wb_i,
  output var  serial_port_pkg::wb_rsp_type wb_o,
  // Baud source
  input  wire logic                       timer1_ovf_i,
  // Line pins
  input  wire logic                       rxd_i,
  output logic                            rxd_o,
  output logic                            rxd_oe_o,
  output logic                            txd_o
);
  import serial_port_pkg::*;

  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : bit_rev

  logic [7:0]   ctl_q;
  logic [7:0]   pwr_q;
  logic [7:0]   tmode_q;
  logic [7:0]   rx_buf_q;
  logic         ack_q;
  logic [31:0]  rdat_q;
  logic [2:0]   ms_q;
  logic         half_q;
  logic         ovf_half_q;
  logic         tick;
  logic [3:0]   tx_div_q;
  logic         tx_roll;
  tx_state_type tx_state_q;
  logic [8:0]   tsh_q;
  logic         tx_last_q;
  rx_state_type rx_state_q;
  logic [8:0]   rsh_q;
  logic [3:0]   rx_div_q;
  logic         rx_last_q;
  logic         samp_a_q;
  logic         samp_b_q;
  logic         rxd_meta_q;
  logic         rxd_s_q;
  logic         rxd_prev_q;
  logic         wr_any;
  logic         wr_buf;
  logic         wr_ctl;
  logic [1:0]   mode;
  logic         dbl;
  logic         s6;
  logic         shclk_low;
  logic         majority;
  logic [8:0]   rsh_next;
  logic         tx_done_set;
  logic         rx_done_set;
  logic         rx_load;
  logic         m1_edge;

  assign mode      = {ctl_q[`SP_CTL_MODE_HI], ctl_q[`SP_CTL_MODE_LO]};
  assign dbl       = pwr_q[`SP_PWR_DOUBLE];
  assign s6        = (ms_q == `SP_ST_S6);
  assign shclk_low = (ms_q >= `SP_ST_S3) && (ms_q <= `SP_ST_S5);

  // Bus: ack one cycle after the strobe, writes land on the ack edge
  assign wr_any = wb_i.cyc && wb_i.stb && wb_i.we && ack_q && wb_i.sel[0];
  assign wr_buf = wr_any && (wb_i.adr[3:2] == `SP_IDX_BUFFER);
  assign wr_ctl = wr_any && (wb_i.adr[3:2] == `SP_IDX_CONTROL);
  assign wb_o.ack = ack_q;
  assign wb_o.dat = rdat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_i.cyc && wb_i.stb && !ack_q;
      if (wb_i.cyc && wb_i.stb && !ack_q) begin
        case (wb_i.adr[3:2])
          `SP_IDX_BUFFER:  rdat_q <= {24'h00_0000, rx_buf_q};
          `SP_IDX_CONTROL: rdat_q <= {24'h00_0000, ctl_q};
          `SP_IDX_POWER:   rdat_q <= {24'h00_0000, pwr_q};
          default:         rdat_q <= {24'h00_0000, tmode_q};
        endcase
      end
    end
  end

  // Timer mode is only held for software; the timer itself lives outside
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q   <= `SP_REG_RESET;
      tmode_q <= `SP_REG_RESET;
    end else if (wr_any && wb_i.adr[3:2] == `SP_IDX_POWER) begin
      pwr_q <= wb_i.dat[7:0];
    end else if (wr_any && wb_i.adr[3:2] == `SP_IDX_TMODE) begin
      tmode_q <= wb_i.dat[7:0];
    end
  end

  // Done flags: a hardware set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= `SP_REG_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_q <= wb_i.dat[7:0];
      end
      if (tx_done_set) begin
        ctl_q[`SP_CTL_TXDONE] <= 1'b1;
      end
      if (rx_done_set) begin
        ctl_q[`SP_CTL_RXDONE] <= 1'b1;
      end
      if (rx_load && mode != 2'h0) begin
        ctl_q[`SP_CTL_RX9] <= majority;
      end
    end
  end

  // Machine cycle of six CPU clocks, one mode 0 bit each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_q <= `SP_ST_S1;
    end else if (s6) begin
      ms_q <= `SP_ST_S1;
    end else begin
      ms_q <= ms_q + 3'h1;
    end
  end

  // 16x tick: mode 2 from the CPU clock, modes 1/3 from overflows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_q     <= 1'b0;
      ovf_half_q <= 1'b0;
    end else begin
      half_q <= !half_q;
      if (timer1_ovf_i) begin
        ovf_half_q <= !ovf_half_q;
      end
    end
  end

  always_comb begin
    case (mode)
      2'h2:    tick = dbl || half_q;
      2'h0:    tick = 1'b0;
      default: tick = timer1_ovf_i && (dbl || ovf_half_q);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_div_q <= 4'h0;
    end else if (tick) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end
  assign tx_roll = tick && (tx_div_q == `SP_DIV_LAST);

  // Transmitter for both modes
  assign tx_done_set = (mode == 2'h0)
                     ? (tx_state_q == TX_SEND && tx_last_q &&
                        ms_q == `SP_ST_S1)
                     : (tx_state_q == TX_DATA && tx_roll &&
                        tsh_q[8:1] == `SP_TX_MARK);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_q <= TX_IDLE;
      tsh_q      <= 9'h000;
      tx_last_q  <= 1'b0;
    end else if (wr_buf) begin
      tsh_q      <= {1'b1, wb_i.dat[7:0]};
      tx_state_q <= TX_WAIT;
      tx_last_q  <= 1'b0;
    end else if (mode == 2'h0) begin
      case (tx_state_q)
        TX_WAIT: begin
          if (s6) begin
            tx_state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_done_set) begin
            tx_state_q <= TX_IDLE;
            tx_last_q  <= 1'b0;
          end else if (s6 && !tx_last_q) begin
            tsh_q <= {1'b0, tsh_q[8:1]};
            tx_last_q <= (tsh_q[8:1] == `SP_TX_MARK);
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end else begin
      case (tx_state_q)
        TX_WAIT: begin
          if (tx_roll) begin
            tx_state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_roll) begin
            tx_state_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_roll) begin
            tsh_q <= {1'b0, tsh_q[8:1]};
            if (tsh_q[8:1] == `SP_TX_MARK) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Pin synchroniser; the previous level is taken at the 16x rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_meta_q <= 1'b1;
      rxd_s_q    <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_meta_q <= rxd_i;
      rxd_s_q    <= rxd_meta_q;
      if (tick) begin
        rxd_prev_q <= rxd_s_q;
      end
    end
  end

  // Receiver
  assign majority = (samp_a_q & samp_b_q) | (samp_a_q & rxd_s_q) |
                    (samp_b_q & rxd_s_q);
  assign m1_edge  = (mode != 2'h0) && rx_state_q == RX_IDLE &&
                    ctl_q[`SP_CTL_REN] && tick && rxd_prev_q &&
                    !rxd_s_q;
  assign rsh_next = (mode == 2'h0) ? {1'b0, rsh_q[6:0], samp_a_q}
                                   : {rsh_q[7:0], majority};

  always_comb begin
    rx_load     = 1'b0;
    rx_done_set = 1'b0;
    if (mode == 2'h0) begin
      rx_load     = rx_state_q == RX_BUSY && s6 && !rx_last_q &&
                    !rsh_q[7];
      rx_done_set = rx_state_q == RX_BUSY && rx_last_q &&
                    ms_q == `SP_ST_S1;
    end else if (rx_state_q == RX_BUSY && tick &&
                 rx_div_q == `SP_SAMP_C && !rsh_q[8]) begin
      rx_load     = !ctl_q[`SP_CTL_RXDONE] &&
                    (!ctl_q[`SP_CTL_MPF] || majority);
      rx_done_set = rx_load;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf_q <= 8'h00;
    end else if (rx_load) begin
      rx_buf_q <= (mode == 2'h0) ? bit_rev(rsh_next[7:0])
                                 : bit_rev(rsh_q[7:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_q <= RX_IDLE;
      rsh_q      <= 9'h000;
      rx_div_q   <= 4'h0;
      rx_last_q  <= 1'b0;
      samp_a_q   <= 1'b1;
      samp_b_q   <= 1'b1;
    end else if (mode == 2'h0) begin
      case (rx_state_q)
        RX_IDLE: begin
          if (ctl_q[`SP_CTL_REN] && !ctl_q[`SP_CTL_RXDONE]) begin
            rx_state_q <= RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (s6) begin
            rsh_q      <= {1'b0, `SP_RX_PRELOAD0};
            rx_state_q <= RX_BUSY;
            rx_last_q  <= 1'b0;
          end
        end
        RX_BUSY: begin
          if (ms_q == `SP_ST_S5) begin
            samp_a_q <= rxd_s_q;
          end
          if (rx_done_set) begin
            rx_state_q <= RX_IDLE;
            rx_last_q  <= 1'b0;
          end else if (s6 && !rx_last_q) begin
            rsh_q     <= rsh_next;
            rx_last_q <= !rsh_q[7];
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (m1_edge) begin
            rx_div_q   <= 4'h0;
            rsh_q      <= `SP_RX_PRELOAD1;
            rx_state_q <= RX_BUSY;
          end
        end
        RX_BUSY: begin
          if (tick) begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_div_q == `SP_SAMP_A) begin
              samp_a_q <= rxd_s_q;
            end
            if (rx_div_q == `SP_SAMP_B) begin
              samp_b_q <= rxd_s_q;
            end
            if (rx_div_q == `SP_SAMP_C) begin
              if (rsh_q == `SP_RX_PRELOAD1 && majority) begin
                rx_state_q <= RX_IDLE;
              end else if (!rsh_q[8]) begin
                rx_state_q <= RX_IDLE;
              end else begin
                rsh_q <= rsh_next;
              end
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Pins: mode 0 drives data and shift clock, mode 1 drives the line
  always_comb begin
    rxd_o    = 1'b1;
    rxd_oe_o = 1'b0;
    txd_o    = 1'b1;
    if (mode == 2'h0) begin
      if (tx_state_q == TX_SEND) begin
        rxd_o    = tsh_q[0];
        rxd_oe_o = 1'b1;
      end
      if (tx_state_q == TX_SEND || rx_state_q == RX_BUSY) begin
        txd_o = !shclk_low;
      end
    end else if (tx_state_q == TX_SEND) begin
      txd_o = 1'b0;
    end else if (tx_state_q == TX_DATA) begin
      txd_o = tsh_q[0];
    end
  end

  // Checks
  AST_M0_CLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == 2'h0 && tx_state_q == TX_SEND && s6 &&
     $past(tx_state_q == TX_SEND)) |-> txd_o && !$past(txd_o))
    else $error("mode 0 shift clock did not rise at S6");
  AST_M0_SHIFT: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == 2'h0 && tx_state_q == TX_SEND && s6 && !tx_last_q &&
     !wr_buf && !$changed(mode))
    |=> tsh_q == {1'b0, $past(tsh_q[8:1])})
    else $error("mode 0 transmit shift missing");
  // The last shift happens at S6; send drops and the flag rises at S1
  AST_M0_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == 2'h0 && tx_state_q == TX_SEND && s6 && !tx_last_q &&
     tsh_q[8:1] == `SP_TX_MARK && !wr_buf)
    |=> ##1 (tx_state_q == TX_IDLE && ctl_q[`SP_CTL_TXDONE]))
    else $error("mode 0 transmit did not finish at S1");
  AST_M0_PRELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == 2'h0 && rx_state_q == RX_WAIT && s6 && !$changed(mode))
    |=> rsh_q[7:0] == `SP_RX_PRELOAD0 && rx_state_q == RX_BUSY)
    else $error("mode 0 receive preload wrong");
  AST_M2_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == 2'h2 && !dbl && tick) |=> !tick || mode != 2'h2 || dbl)
    else $error("mode 2 undoubled tick too fast");
  AST_M1_START: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == 2'h1 && tx_state_q == TX_WAIT && tx_roll && !wr_buf &&
     !wr_ctl) |=> tx_state_q == TX_SEND && !txd_o)
    else $error("start bit not driven after rollover");
  AST_M1_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    m1_edge && !$changed(mode) |=> rx_div_q == 4'h0 &&
    rsh_q == `SP_RX_PRELOAD1)
    else $error("edge did not reset receive divider");
  // An unread byte must survive any frame in modes 1 to 3 that ends meanwhile
  AST_RX_GUARD: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode != 2'h0 && ctl_q[`SP_CTL_RXDONE]) |=> $stable(rx_buf_q))
    else $error("frame loaded against guard");
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

  COV_M0_TX: cover property (@(posedge clk_i) disable iff (rst_i)
    mode == 2'h0 && tx_done_set);
  COV_M1_RX: cover property (@(posedge clk_i) disable iff (rst_i)
    mode == 2'h1 && rx_load);
  COV_ABORT: cover property (@(posedge clk_i) disable iff (rst_i)
    mode == 2'h1 && rx_state_q == RX_BUSY ##1 rx_state_q == RX_IDLE &&
    !$past(rx_load));

endmodule : serial_port_core

`default_nettype wire

// File: rtl/serial_port_params.svh
// Constants for the serial port: register map, field layout, timing.
// Included by the core only; holds definitions only.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// Register word indices on the Wishbone bus (byte address = 4 * index)
`define SP_IDX_BUFFER      2'h0
`define SP_IDX_CONTROL     2'h1
`define SP_IDX_POWER       2'h2
`define SP_IDX_TMODE       2'h3

// Control and power register fields, register reset value
`define SP_CTL_MODE_HI     7
`define SP_CTL_MODE_LO     6
`define SP_CTL_MPF         5
`define SP_CTL_REN         4
`define SP_CTL_TX9         3
`define SP_CTL_RX9         2
`define SP_CTL_TXDONE      1
`define SP_CTL_RXDONE      0
`define SP_PWR_DOUBLE      7
`define SP_REG_RESET       8'h00

// Machine cycle: six CPU clocks, S1..S6 counted 0..5
`define SP_ST_S1           3'h0
`define SP_ST_S3           3'h2
`define SP_ST_S5           3'h4
`define SP_ST_S6           3'h5

// Divide-by-16 bit timing and majority sample points
`define SP_DIV_LAST        4'hf
`define SP_SAMP_A          4'h7
`define SP_SAMP_B          4'h8
`define SP_SAMP_C          4'h9
`define SP_RX_PRELOAD0     8'hfe
`define SP_RX_PRELOAD1     9'h1ff
`define SP_TX_MARK         8'h01

`endif

// File: rtl/serial_port_pkg.sv
// Types shared by the serial port core and its bench.
// Assumes the params header is on the include path.
package serial_port_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b11,
    TX_DATA = 2'b10
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_WAIT = 2'b01,
    RX_BUSY = 2'b11
  } rx_state_type;

endpackage : serial_port_pkg

// File: testbench/serial_port_partner.sv
// Far-end model: mode 0 shift register peer and asynchronous peer.
// Assumes the bench resolves the data wire and sets the bit length.
`timescale 1ns/10ps
`default_nettype none

module serial_port_partner (
  // Clock and setup
  input  wire logic        clk_i,
  input  wire logic        mode1_i,
  input  wire logic [15:0] bit_len_i,
  // Line
  input  wire logic        txd_i,
  input  wire logic        line_i,
  input  wire logic        oe_i,
  output logic             drv_o
);
  logic [8:0] got_q[$];
  logic [8:0] fr;
  logic [7:0] sh0;
  logic [7:0] d0;
  logic [7:0] per0;
  logic [7:0] low0;
  logic [7:0] pcnt;
  logic [7:0] lcnt;
  logic [2:0] k0;
  logic [2:0] j0;
  logic       txd_l;
  logic       arm0;
  logic       m0;
  logic       u1;

  initial begin
    k0 = 3'h0;
    arm0 = 1'b0;
    m0 = 1'b0;
    u1 = 1'b1;
    pcnt = 8'h00;
    lcnt = 8'h00;
  end

  assign drv_o = mode1_i ? u1 : m0;

  always @(posedge clk_i) begin
    txd_l <= txd_i;
    pcnt <= pcnt + 8'h01;
    lcnt <= txd_i ? 8'h00 : lcnt + 8'h01;
    // An idle peer flips its pin so a stale value never passes
    if (!arm0) m0 <= ~m0;
    if (!mode1_i && txd_l && !txd_i) begin
      per0 <= pcnt;
      pcnt <= 8'h01;
      if (oe_i) begin
        sh0 <= {line_i, sh0[7:1]};
        k0 <= k0 + 3'h1;
        if (k0 == 3'h7) got_q.push_back({1'b1, line_i, sh0[7:1]});
      end
    end
    if (!mode1_i && !txd_l && txd_i) begin
      low0 <= lcnt;
      if (arm0) begin
        m0 <= d0[j0 + 3'h1];
        j0 <= j0 + 3'h1;
        if (j0 == 3'h7) arm0 <= 1'b0;
      end
    end
  end

  // Receives start, eight data bits LSB first, stop
  always @(posedge clk_i) begin
    if (mode1_i && txd_l && !txd_i) begin
      repeat (bit_len_i / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_len_i) @(posedge clk_i);
        fr = {txd_i, fr[8:1]};
      end
      got_q.push_back(fr);
    end
  end

  // Stop the idle toggling first, then present bit 0 on the next edge
  task automatic arm(input logic [7:0] d);
    d0 = d;
    j0 = 3'h0;
    arm0 = 1'b1;
    @(posedge clk_i);
    m0 <= d[0];
  endtask : arm

  // Optional short low pulse first, to be rejected as a false start
  task automatic send1(input logic [7:0] d, input logic stop,
                       input logic glitch);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    if (glitch) begin
      u1 <= 1'b0;
      repeat (bit_len_i * 5 / 16) @(posedge clk_i);
      u1 <= 1'b1;
      repeat (bit_len_i) @(posedge clk_i);
    end
    for (int i = 0; i < 10; i++) begin
      u1 <= f[i];
      repeat (bit_len_i) @(posedge clk_i);
    end
    u1 <= 1'b1;
  endtask : send1
endmodule : serial_port_partner
`default_nettype wire

// File: testbench/serial_port_baud_mode0_mode1_tb_top.sv
// Bench for the serial port core: bus tasks, reference model, checks.
// Assumes the package, the core and the partner model are compiled.
`timescale 1ns/10ps
`default_nettype none

module serial_port_baud_mode0_mode1_tb_top;
  import serial_port_pkg::*;
  logic        clk_i;
  logic        rst_i;
  wb_req_type  wb_i;
  wb_rsp_type  wb_o;
  logic        timer1_ovf_i;
  logic        rxd_o;
  logic        rxd_oe_o;
  logic        txd_o;
  logic        part_drv;
  logic        mode1;
  logic [15:0] bit_len;
  logic [1:0]  ovf_cnt;
  logic [31:0] seed;
  logic [7:0]  q;
  logic [7:0]  d;
  logic [7:0]  buf_m;
  logic [8:0]  f;
  logic        rxdone_m;
  logic        rb8_m;
  logic        ren_m;
  logic        mpf_m;
  int          err_count;
  int          checked;
  logic [7:0]  tc[5] = '{8'h40, 8'h40, 8'h80, 8'h80, 8'hc0};
  logic [7:0]  tp[5] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h80};
  logic [15:0] tl[5] = '{16'd64, 16'd128, 16'd16, 16'd32, 16'd64};
  logic [7:0]  rc[6] = '{8'h50, 8'hff, 8'h70, 8'h70, 8'h40, 8'h50};
  logic        rs[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic        rg[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  wire logic   rxd_line = rxd_oe_o ? rxd_o : part_drv;

  serial_port_core i_serial_port_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .timer1_ovf_i(timer1_ovf_i), .rxd_i(rxd_line), .rxd_o(rxd_o),
    .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));

  serial_port_partner i_serial_port_partner (
    .clk_i(clk_i), .mode1_i(mode1), .bit_len_i(bit_len), .txd_i(txd_o),
    .line_i(rxd_line), .oe_i(rxd_oe_o), .drv_o(part_drv));

  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  // Overflow every fourth clock: 64 clocks a bit when doubled
  always @(posedge clk_i) begin
    ovf_cnt <= ovf_cnt + 2'h1;
    timer1_ovf_i <= (ovf_cnt == 2'h3);
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic cmp(input string what, input logic [8:0] exp,
                     input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wb(input logic we, input logic [1:0] idx,
                    input logic [7:0] dv);
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, dv}};
    do begin
      @(posedge clk_i);
    end while (wb_o.ack !== 1'b1);
    q = wb_o.dat[7:0];
    wb_i <= '0;
    @(posedge clk_i);
  endtask : wb

  // Polls until the bit reads 1; only the watchdog ends a stuck wait
  task automatic poll(input int b);
    do begin
      wb(1'b0, 2'h1, 8'h00);
    end while (q[b] !== 1'b1);
  endtask : poll

  task automatic take();
    while (i_serial_port_partner.got_q.size() == 0) begin
      @(posedge clk_i);
    end
    f = i_serial_port_partner.got_q.pop_front();
  endtask : take

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    test_done();
  end

  initial begin
    wb_i = '0;
    rst_i = 1'b1;
    timer1_ovf_i = 1'b0;
    ovf_cnt = 2'h0;
    mode1 = 1'b0;
    bit_len = 16'd64;
    seed = 32'd85069;
    err_count = 0;
    checked = 0;
    buf_m = 8'h00;
    rxdone_m = 1'b0;
    rb8_m = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp("idle lines", 9'h001, {7'h0, rxd_oe_o, txd_o});
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 2'(i), 8'h00);
      cmp("reset value", 9'h000, {1'b0, q});
    end
    wb(1'b1, 2'h3, 8'h20);
    wb(1'b0, 2'h3, 8'h00);
    cmp("timer mode", 9'h020, {1'b0, q});
    $display("test reset done");
    d = rnd();
    wb(1'b1, 2'h0, d);
    take();
    cmp("mode0 tx", {1'b1, d}, f);
    cmp("shift period", 9'd6, {1'b0, i_serial_port_partner.per0});
    cmp("shift low", 9'd3, {1'b0, i_serial_port_partner.low0});
    poll(1);
    cmp("tx done", 9'h001, {8'h0, q[1]});
    wb(1'b0, 2'h0, 8'h00);
    cmp("rx buffer", 9'h000, {1'b0, q});
    d = rnd();
    i_serial_port_partner.arm(d);
    wb(1'b1, 2'h1, 8'h10);
    poll(0);
    cmp("rx done", 9'h001, {8'h0, q[0]});
    wb(1'b0, 2'h0, 8'h00);
    cmp("mode0 rx", {1'b0, d}, {1'b0, q});
    buf_m = d;
    $display("test mode0 done");
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 2'h1, tc[i]);
      wb(1'b1, 2'h2, tp[i]);
      bit_len <= tl[i];
      mode1 <= 1'b1;
      d = rnd();
      wb(1'b1, 2'h0, d);
      take();
      cmp("async tx", {1'b1, d}, f);
      poll(1);
      cmp("tx done", 9'h001, {8'h0, q[1]});
    end
    $display("test async tx done");
    wb(1'b1, 2'h2, 8'h80);
    bit_len <= 16'd64;
    for (int i = 0; i < 6; i++) begin
      if (rc[i] != 8'hff) begin
        wb(1'b1, 2'h1, rc[i]);
        // A control write replaces every bit, the ninth bit too
        rxdone_m = rc[i][0];
        rb8_m = rc[i][2];
        ren_m = rc[i][4];
        mpf_m = rc[i][5];
      end
      d = rnd();
      i_serial_port_partner.send1(d, rs[i], rg[i]);
      repeat (4) @(posedge clk_i);
      if (ren_m && !rxdone_m && (!mpf_m || rs[i])) begin
        buf_m = d;
        rb8_m = rs[i];
        rxdone_m = 1'b1;
      end
      wb(1'b0, 2'h1, 8'h00);
      cmp("rx flags", {7'h0, rb8_m, rxdone_m}, {7'h0, q[2], q[0]});
      wb(1'b0, 2'h0, 8'h00);
      cmp("rx buffer", {1'b0, buf_m}, {1'b0, q});
      cmp("rx case", {1'b0, buf_m}, {1'b0, q});
    end
    $display("test async rx done");
    test_done();
  end
endmodule : serial_port_baud_mode0_mode1_tb_top
`default_nettype wire
